// ---- sae_pkg.sv ----
package sae_pkg;

   // Frame layouts the encoder can be built for
   typedef enum logic [2:0] {
      FMT_VALID_24     = 3'h0,
      FMT_PARITY_24    = 3'h1,
      FMT_BINARY_16    = 3'h2,
      FMT_TIMESTAMP_32 = 3'h3,
      FMT_GRAY_16      = 3'h4
   } sae_fmt_t;

   // System clock
   localparam int CLK_PERIOD_NS = 10;
   localparam int CLK_HZ = 100_000_000;

   // Message update time, nominal and upper tolerance
   localparam int TMU_NS = 20_000;
   localparam int TMU_TOL_NS = 1_000;
   localparam int TMU_CYC = TMU_NS / CLK_PERIOD_NS;
   localparam int TMU_MAX_CYC = (TMU_NS + TMU_TOL_NS) / CLK_PERIOD_NS;

   // Serial clock limits; half period rounded up so 2 MHz is never exceeded
   localparam int SCLK_MAX_HZ = 2_000_000;
   localparam int SCLK_MIN_HZ = 100_000;
   localparam int HALF_MIN_CYC = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
   localparam int HALF_MAX_CYC = CLK_HZ / (2 * SCLK_MIN_HZ);

   // Timestamp counter: 10 us steps, 11 bits wrap after 20.48 ms
   localparam int TS_STEP_NS = 10_000;
   localparam int TS_STEP_CYC = TS_STEP_NS / CLK_PERIOD_NS;
   localparam int TS_W = 11;

   // Zero strap hold time at power-up
   localparam int ZERO_HOLD_S = 5;
   localparam int ZERO_HOLD_CYC = ZERO_HOLD_S * CLK_HZ;

   // Field positions
   localparam int FRAME_MAX = 32;
   localparam int POS_MAX = 22;
   localparam int V24_PV_BIT = 23;
   localparam int V24_ZFD_BIT = 22;
   localparam int P24_POS_LSB = 2;
   localparam int P24_PAR_BIT = 1;
   localparam int P24_ALM_BIT = 0;
   localparam int T32_PV_BIT = 31;
   localparam int T32_ZFD_BIT = 30;
   localparam int T32_POS_LSB = 11;
   localparam int T32_POS_W = 19;
   localparam int W16_POS_W = 16;

   // Frame length n, error flag excluded
   function automatic logic [5:0] frame_len(input sae_fmt_t f);
      case (f)
         FMT_BINARY_16, FMT_GRAY_16: frame_len = 6'h10;
         FMT_TIMESTAMP_32: frame_len = 6'h20;
         default: frame_len = 6'h18;
      endcase
   endfunction

endpackage

// ---- sae_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// Serial link: clock from the controller, data from the encoder
interface sae_link_if;
   logic sclk;
   logic sdata;
   modport host (output sclk, input sdata);
   modport dev (input sclk, output sdata);
endinterface

`default_nettype wire

// ---- sae_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

module sae_fifo #(
   parameter int W = 33,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, rd_q;
   logic [AW:0] cnt_q;
   logic push, pop;

   // Full and empty come straight from the occupancy count
   assign in_ready_o = (cnt_q != (AW + 1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_q];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // Storage
   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   // Pointers and count; DEPTH is a power of two so pointers wrap freely
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop) rd_q <= rd_q + 1'b1;
         if (push && !pop) cnt_q <= cnt_q + 1'b1;
         else if (pop && !push) cnt_q <= cnt_q - 1'b1;
      end
   end

endmodule // sae_fifo

`default_nettype wire

// ---- sae_encoder_dev.sv ----
`timescale 1ns/1ps
`default_nettype none

module sae_encoder_dev
   import sae_pkg::*;
#(
   parameter sae_fmt_t FMT = FMT_VALID_24,
   parameter int RES = 16,
   parameter int HOLD_CYC = ZERO_HOLD_CYC
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Serial link
   sae_link_if.dev link,
   // Position measurement from the sensing core
   input wire logic pos_stb_i,
   input wire logic [RES-1:0] pos_raw_i,
   input wire logic pos_err_i,
   // Zero strap pins, active low
   input wire logic zero_set_n_i,
   input wire logic zero_reset_n_i,
   // Nonvolatile zero datum
   input wire logic [RES-1:0] nv_offset_i,
   input wire logic nv_factory_i,
   output logic nv_wr_o,
   output logic [RES-1:0] nv_offset_o,
   output logic nv_factory_o
);

   typedef enum logic {
      D_IDLE = 1'b0,
      D_READ = 1'b1
   } sae_dst_t;

   localparam logic [5:0] FRAME_N = frame_len(FMT);

   sae_dst_t state_q;
   logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
   logic sclk_fall, sclk_rise;
   logic [15:0] tmu_q;
   logic [5:0] rise_q;
   logic [FRAME_MAX-1:0] frame_q, frame_d, frame_idx_w;
   logic frame_err_q, data_q, smp_err_q, factory_q, loaded_q, nv_wr_q;
   logic [9:0] ts_div_q;
   logic [TS_W-1:0] ts_q, smp_ts_q;
   logic [RES-1:0] smp_pos_q, offset_q;
   logic [1:0] strap_n, strap_s1_q, strap_s2_q, strap_arm_q, strap_hit_q;
   logic [31:0] strap_cnt_q [2];
   logic [POS_MAX-1:0] pos22;

   assign link.sdata = data_q;
   assign nv_wr_o = nv_wr_q;
   assign nv_offset_o = offset_q;
   assign nv_factory_o = factory_q;

   // Link clock is foreign: two flops, then a third for edge finding
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sclk_s1_q <= 1'b1;
         sclk_s2_q <= 1'b1;
         sclk_s3_q <= 1'b1;
      end else begin
         sclk_s1_q <= link.sclk;
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
      end
   end

   assign sclk_fall = sclk_s3_q && !sclk_s2_q;
   assign sclk_rise = !sclk_s3_q && sclk_s2_q;

   // Timestamp: free running, 11 bits wrap from 2047 to 0 by themselves
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ts_div_q <= '0;
         ts_q <= '0;
      end else if (ts_div_q == 10'(TS_STEP_CYC - 1)) begin
         ts_div_q <= '0;
         ts_q <= ts_q + 1'b1;
      end else begin
         ts_div_q <= ts_div_q + 1'b1;
      end
   end

   // Sample capture: position relative to the zero datum, stamped on arrival
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         smp_pos_q <= '0;
         smp_err_q <= 1'b1;
         smp_ts_q <= '0;
      end else if (pos_stb_i) begin
         smp_pos_q <= pos_raw_i - offset_q;
         smp_err_q <= pos_err_i;
         smp_ts_q <= ts_q;
      end
   end

   // Zero straps, synchronised since they are pins
   assign strap_n = {zero_reset_n_i, zero_set_n_i};

   // Each strap must stay low for the full hold from reset release; releasing it early disarms it.
   // The first two counts are spent while the synchroniser still shows its reset level
   for (genvar i = 0; i < 2; i++) begin : g_strap
      always_ff @(posedge ref_clk_i or posedge rst_i) begin
         if (rst_i) begin
            strap_s1_q[i] <= 1'b1;
            strap_s2_q[i] <= 1'b1;
            strap_arm_q[i] <= 1'b1;
            strap_hit_q[i] <= 1'b0;
            strap_cnt_q[i] <= '0;
         end else begin
            strap_s1_q[i] <= strap_n[i];
            strap_s2_q[i] <= strap_s1_q[i];
            strap_hit_q[i] <= 1'b0;
            if (strap_arm_q[i]) begin
               if (strap_s2_q[i] && strap_cnt_q[i] > 32'h0000_0001) begin
                  strap_arm_q[i] <= 1'b0;
               end else if (strap_cnt_q[i] == 32'(HOLD_CYC - 1)) begin
                  strap_arm_q[i] <= 1'b0;
                  strap_hit_q[i] <= 1'b1;
               end else begin
                  strap_cnt_q[i] <= strap_cnt_q[i] + 1'b1;
               end
            end
         end
      end
   end

   // Zero datum: restored from storage once, then changed only by straps
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         offset_q <= '0;
         factory_q <= 1'b1;
         loaded_q <= 1'b0;
         nv_wr_q <= 1'b0;
      end else begin
         nv_wr_q <= 1'b0;
         if (!loaded_q) begin
            loaded_q <= 1'b1;
            offset_q <= nv_offset_i;
            factory_q <= nv_factory_i;
         end else if (strap_hit_q[1]) begin
            offset_q <= '0;
            factory_q <= 1'b1;
            nv_wr_q <= 1'b1;
         end else if (strap_hit_q[0]) begin
            offset_q <= offset_q + smp_pos_q;
            factory_q <= 1'b0;
            nv_wr_q <= 1'b1;
         end
      end
   end

   // Frame assembly from the latest sample; unused MSBs stay zero
   assign pos22 = POS_MAX'(smp_pos_q);
   always_comb begin
      frame_d = '0;
      case (FMT)
         FMT_VALID_24: begin
            frame_d[V24_PV_BIT] = !smp_err_q;
            frame_d[V24_ZFD_BIT] = factory_q;
            frame_d[POS_MAX-1:0] = pos22;
         end
         FMT_PARITY_24: begin
            frame_d[P24_POS_LSB +: POS_MAX] = pos22;
            frame_d[P24_PAR_BIT] = ^pos22;
            frame_d[P24_ALM_BIT] = smp_err_q;
         end
         FMT_BINARY_16: begin
            frame_d[W16_POS_W-1:0] = pos22[W16_POS_W-1:0];
         end
         FMT_TIMESTAMP_32: begin
            frame_d[T32_PV_BIT] = !smp_err_q;
            frame_d[T32_ZFD_BIT] = factory_q;
            frame_d[T32_POS_LSB +: T32_POS_W] = pos22[T32_POS_W-1:0];
            frame_d[TS_W-1:0] = smp_ts_q;
         end
         FMT_GRAY_16: begin
            frame_d[W16_POS_W-1:0] = pos22[W16_POS_W-1:0] ^ (pos22[W16_POS_W-1:0] >> 1);
         end
         default: frame_d = '0;
      endcase
   end

   // Read cycle sequencing; the update timer restarts on every falling edge
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= D_IDLE;
         tmu_q <= '0;
         rise_q <= '0;
      end else begin
         case (state_q)
            D_IDLE: begin
               if (sclk_fall) begin
                  state_q <= D_READ;
                  tmu_q <= '0;
                  rise_q <= '0;
               end
            end
            D_READ: begin
               if (sclk_fall) begin
                  tmu_q <= '0;
               end else if (tmu_q == 16'(TMU_CYC - 1)) begin
                  state_q <= D_IDLE;
               end else begin
                  tmu_q <= tmu_q + 1'b1;
               end
               if (sclk_rise && rise_q != FRAME_N) begin
                  rise_q <= rise_q + 1'b1;
               end
            end
            default: state_q <= D_IDLE;
         endcase
      end
   end

   // Frame register tracks the newest sample while idle, frozen for the read
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         frame_q <= '0;
         frame_err_q <= 1'b1;
      end else if (state_q == D_IDLE && !sclk_fall) begin
         frame_q <= frame_d;
         frame_err_q <= smp_err_q;
      end
   end

   assign frame_idx_w = frame_q >> (FRAME_N - 6'h01 - rise_q);

   // Data line: high when idle, bits on rising edges, then the error flag
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         data_q <= 1'b1;
      end else if (state_q == D_IDLE) begin
         data_q <= 1'b1;
      end else if (sclk_rise) begin
         if (rise_q < FRAME_N) begin
            data_q <= frame_idx_w[0];
         end else begin
            data_q <= frame_err_q;
         end
      end
   end

endmodule // sae_encoder_dev

`default_nettype wire

// ---- sae_ssi_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module sae_ssi_host
   import sae_pkg::*;
#(
   parameter sae_fmt_t FMT = FMT_VALID_24,
   parameter int HALF_CYC = HALF_MIN_CYC,
   parameter int GAP_CYC = TMU_MAX_CYC + 1,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Serial link
   sae_link_if.host link,
   // Polling control
   input wire logic read_en_i,
   // Received frames, error flag on top
   output logic rd_valid_o,
   input wire logic rd_ready_i,
   output logic [FRAME_MAX-1:0] rd_frame_o,
   output logic rd_err_o
);

   typedef enum logic [1:0] {
      H_GAP = 2'h0,
      H_LOW = 2'h1,
      H_HIGH = 2'h2
   } sae_hst_t;

   localparam logic [5:0] FRAME_N = frame_len(FMT);

   sae_hst_t state_q;
   logic sclk_q;
   logic [15:0] cnt_q;
   logic [5:0] rise_q;
   logic [FRAME_MAX-1:0] shift_q;
   logic push_q;
   logic push_err_q;
   logic sd_s1_q, sd_s2_q;
   logic fifo_ready;

   assign link.sclk = sclk_q;

   // Data is foreign to this clock: two flops before use
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sd_s1_q <= 1'b1;
         sd_s2_q <= 1'b1;
      end else begin
         sd_s1_q <= link.sdata;
         sd_s2_q <= sd_s1_q;
      end
   end

   // Clock generation and sampling; a read starts only with room in the FIFO
   // so a stalled consumer halts polling instead of losing frames
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= H_GAP;
         sclk_q <= 1'b1;
         cnt_q <= '0;
         rise_q <= '0;
         shift_q <= '0;
         push_q <= 1'b0;
         push_err_q <= 1'b0;
      end else begin
         push_q <= 1'b0;
         case (state_q)
            H_GAP: begin
               if (cnt_q < 16'(GAP_CYC - 1)) begin
                  cnt_q <= cnt_q + 1'b1;
               end else if (read_en_i && fifo_ready) begin
                  state_q <= H_LOW;
                  sclk_q <= 1'b0;
                  shift_q <= '0; // Right-aligned frame: no bits of the previous read above it
                  cnt_q <= '0;
                  rise_q <= '0;
               end
            end
            H_LOW: begin
               if (cnt_q == 16'(HALF_CYC - 1)) begin
                  state_q <= H_HIGH;
                  sclk_q <= 1'b1;
                  cnt_q <= '0;
                  rise_q <= rise_q + 1'b1;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            H_HIGH: begin
               if (cnt_q == 16'(HALF_CYC - 1)) begin
                  cnt_q <= '0;
                  if (rise_q <= FRAME_N) begin
                     shift_q <= {shift_q[FRAME_MAX-2:0], sd_s2_q};
                     state_q <= H_LOW;
                     sclk_q <= 1'b0;
                  end else begin
                     push_err_q <= sd_s2_q;
                     push_q <= 1'b1;
                     state_q <= H_GAP;
                  end
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            default: begin
               state_q <= H_GAP;
            end
         endcase
      end
   end

   sae_fifo #(
      .W(FRAME_MAX + 1),
      .DEPTH(DEPTH)
   ) u_fifo (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .in_valid_i(push_q),
      .in_ready_o(fifo_ready),
      .in_data_i({push_err_q, shift_q}),
      .out_valid_o(rd_valid_o),
      .out_ready_i(rd_ready_i),
      .out_data_o({rd_err_o, rd_frame_o})
   );

endmodule // sae_ssi_host

`default_nettype wire

// ---- sae_link_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

module sae_link_asserts
   import sae_pkg::*;
#(
   parameter int N = 24
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Link wires
   input wire logic sclk,
   input wire logic sdata
);
   localparam int HMAX = 500;
   localparam int TMU_MIN = (TMU_NS - TMU_TOL_NS) / CLK_PERIOD_NS;
   logic sclk_q;
   logic [5:0] rise_cnt_q;
   logic [11:0] fall_cnt_q;
   logic start_fall;

   // A fall opens a frame when none is open or the last one is complete
   assign start_fall = !sclk && sclk_q && (rise_cnt_q == 6'h00 || rise_cnt_q == 6'(N + 1));

   // Previous clock level, idle high
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sclk_q <= 1'b1;
      end else begin
         sclk_q <= sclk;
      end
   end

   // Rising edges seen since the frame opened
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rise_cnt_q <= 6'h00;
      end else if (start_fall) begin
         rise_cnt_q <= 6'h00;
      end else if (sclk && !sclk_q) begin
         rise_cnt_q <= rise_cnt_q + 6'h01;
      end
   end

   // Cycles since the last fall; saturates so reset looks like a long idle
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fall_cnt_q <= 12'hFFF;
      end else if (!sclk && sclk_q) begin
         fall_cnt_q <= 12'h000;
      end else if (fall_cnt_q != 12'hFFF) begin
         fall_cnt_q <= fall_cnt_q + 12'h001;
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   a_low_min_half: assert property ($fell(sclk) |=> !sclk[*8] ##1 !sclk[*8] ##1 !sclk[*8])
      else $error("clock low phase too short");
   a_high_min_half: assert property ($rose(sclk) |=> sclk[*8] ##1 sclk[*8] ##1 sclk[*8])
      else $error("clock high phase too short");
   a_low_max_half: assert property ($fell(sclk) |-> ##[1:HMAX] sclk)
      else $error("clock low phase too long");
   a_rise_count: assert property ($rose(sclk) |-> rise_cnt_q <= 6'(N))
      else $error("too many rising edges in frame");
   a_gap_before_read: assert property (start_fall |-> fall_cnt_q >= 12'(TMU_MAX_CYC) && sdata)
      else $error("read started before update time");
   a_data_after_rise: assert property ($changed(sdata) |->
      ($past(sclk, 3) && !$past(sclk, 6)) || (sdata && fall_cnt_q >= 12'(TMU_MIN)))
      else $error("data changed away from a rising edge");
   a_flag_holds: assert property (rise_cnt_q == 6'(N + 1) && fall_cnt_q > 12'h040 &&
      fall_cnt_q < 12'(TMU_MIN) |-> $stable(sdata))
      else $error("error flag not held");
   a_release_high: assert property (sclk && fall_cnt_q == 12'(TMU_MAX_CYC) |-> sdata)
      else $error("data not high after update time");

   c_frame_start: cover property (start_fall);
   c_last_rise: cover property ($rose(sclk) && rise_cnt_q == 6'(N));
   c_release: cover property (sclk && fall_cnt_q == 12'(TMU_MAX_CYC) && sdata);
endmodule // sae_link_asserts

`default_nettype wire

// ---- tb_ssi_angle_encoder_port.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_ssi_angle_encoder_port;
   import sae_pkg::*;
   // Long strap hold so a sample lands before the zero action
   localparam int HOLD = 2000;
   localparam int LIMIT = 80000;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic pos_stb = 1'b0;
   logic pos_err = 1'b0;
   logic [15:0] pos_raw = 16'h0000;
   logic zset_n = 1'b1;
   logic zrst_n = 1'b1;
   logic [15:0] nv_off = 16'h0000;
   logic nv_fac = 1'b1;
   logic read_en = 1'b0;
   logic rd_ready = 1'b0;
   wire logic [4:0] rd_valid;
   wire logic [4:0] rd_err;
   wire logic [4:0] nv_wr;
   wire logic [4:0] nv_fac_o;
   wire logic [31:0] rd_frame [5];
   wire logic [15:0] nv_off_o [5];
   int fails = 0;
   int compares = 0;
   int cyc = 0;
   int rel = 0;
   logic [10:0] ts_exp = 11'h000;

   always #5 ref_clk_i = ~ref_clk_i;

   // One encoder and controller pair per format, each on its own link
   for (genvar g = 0; g < 5; g++) begin : g_fmt
      sae_link_if sae_link_if_i ();
      sae_encoder_dev #(.FMT(sae_fmt_t'(g)), .HOLD_CYC(HOLD)) sae_encoder_dev_i (.ref_clk_i(ref_clk_i),
         .rst_i(rst_i), .link(sae_link_if_i.dev), .pos_stb_i(pos_stb), .pos_raw_i(pos_raw), .pos_err_i(pos_err),
         .zero_set_n_i(zset_n), .zero_reset_n_i(zrst_n), .nv_offset_i(nv_off), .nv_factory_i(nv_fac),
         .nv_wr_o(nv_wr[g]), .nv_offset_o(nv_off_o[g]), .nv_factory_o(nv_fac_o[g]));
      sae_ssi_host #(.FMT(sae_fmt_t'(g))) sae_ssi_host_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
         .link(sae_link_if_i.host), .read_en_i(read_en), .rd_valid_o(rd_valid[g]), .rd_ready_i(rd_ready),
         .rd_frame_o(rd_frame[g]), .rd_err_o(rd_err[g]));
      if (g == 0) begin : g_chk
         sae_link_asserts #(.N(24)) sae_link_asserts_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
            .sclk(sae_link_if_i.sclk), .sdata(sae_link_if_i.sdata));
      end
   end

   // Hang guard and time since reset release
   always @(posedge ref_clk_i) begin
      cyc++;
      rel = rst_i ? 0 : rel + 1;
      if (cyc == LIMIT) begin
         fails++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Expected frame, right-aligned, per format
   function automatic logic [31:0] exp_frame(input int f, input logic [15:0] p, input logic e, input logic z);
      case (f)
         0: exp_frame = {8'h00, ~e, z, 6'h00, p};
         1: exp_frame = {8'h00, 6'h00, p, ^p, e};
         2: exp_frame = {16'h0000, p};
         3: exp_frame = {~e, z, 3'h0, p, ts_exp};
         default: exp_frame = {16'h0000, p ^ (p >> 1)};
      endcase
   endfunction

   task automatic do_reset();
      rst_i = 1'b1;
      repeat (8) @(negedge ref_clk_i);
      rst_i = 1'b0;
   endtask

   // Strobe mid-step so the timestamp is unambiguous
   task automatic sample(input logic [15:0] raw, input logic err);
      while (rel % 1000 != 500) @(negedge ref_clk_i);
      pos_raw = raw;
      pos_err = err;
      pos_stb = 1'b1;
      ts_exp = 11'(rel / 1000);
      @(negedge ref_clk_i);
      pos_stb = 1'b0;
   endtask

   // Position is undefined on error, so only flags and timestamp are compared then
   task automatic pop_check(input logic [15:0] p, input logic e, input logic z);
      logic [31:0] m;
      @(negedge ref_clk_i);
      for (int i = 0; i < 8000 && rd_valid !== 5'h1F; i++) @(negedge ref_clk_i);
      for (int f = 0; f < 5; f++) begin
         m = !e ? 32'hFFFF_FFFF : (f == 0) ? 32'h00C0_0000 : (f == 1) ? 32'h0000_0001 : (f == 3) ? 32'hC000_07FF : 32'h0;
         check("frame", exp_frame(f, p, e, z) & m, rd_frame[f] & m);
         check("error flag", {31'h0, e}, {31'h0, rd_err[f]});
      end
      rd_ready = 1'b1;
      @(negedge ref_clk_i);
      rd_ready = 1'b0;
   endtask

   task automatic zero_done(input logic [15:0] off, input logic fac);
      for (int i = 0; i < 4000 && nv_wr[0] !== 1'b1; i++) @(negedge ref_clk_i);
      check("store pulse", 32'h1, {31'h0, nv_wr[0]});
      @(negedge ref_clk_i);
      check("offset", {16'h0000, off}, {16'h0000, nv_off_o[0]});
      check("factory", {31'h0, fac}, {31'h0, nv_fac_o[0]});
   endtask

   initial begin
      // Fill the buffers until reads stop, then drain them
      do_reset();
      read_en = 1'b1;
      repeat (1000) @(negedge ref_clk_i);
      sample(16'h1234, 1'b0);
      repeat (36000) @(negedge ref_clk_i);
      read_en = 1'b0;
      repeat (4000) @(negedge ref_clk_i);
      for (int i = 0; i < 8; i++) pop_check(16'h1234, 1'b0, 1'b1);
      check("empty", 32'h0, {27'h0, rd_valid});
      $display("test fill_drain done");
      // Failed measurement reaches the next frame
      sample(16'h00F0, 1'b1);
      read_en = 1'b1;
      pop_check(16'h00F0, 1'b1, 1'b1);
      $display("test error_flag done");
      // Zero set strap held from power-up
      read_en = 1'b0;
      zset_n = 1'b0;
      do_reset();
      sample(16'h1234, 1'b0);
      zero_done(16'h1234, 1'b0);
      zset_n = 1'b1;
      sample(16'h1240, 1'b0);
      read_en = 1'b1;
      pop_check(16'h000C, 1'b0, 1'b0);
      $display("test zero_set done");
      // Zero reset strap brings back the factory datum
      read_en = 1'b0;
      nv_off = 16'h1234;
      nv_fac = 1'b0;
      zrst_n = 1'b0;
      do_reset();
      zero_done(16'h0000, 1'b1);
      zrst_n = 1'b1;
      sample(16'h0055, 1'b0);
      read_en = 1'b1;
      pop_check(16'h0055, 1'b0, 1'b1);
      $display("test zero_reset done");
      report_and_stop();
   end
endmodule // tb_ssi_angle_encoder_port

`default_nettype wire
